// ==== hdl/rss_pkg.sv ====
package rss_pkg;
  typedef enum logic [1:0] {
    WK_IDLE,
    WK_LOW,
    WK_ARMED
  } rss_wake_e;
  typedef logic [17:0] rss_tcnt_t;
  typedef logic [11:0] rss_fcnt_t;
endpackage

// ==== hdl/rss_pulse_timer.sv ====
`timescale 1ns/1ps
`include "rss_regs.svh"
module rss_pulse_timer #(
  parameter int T_RST_CYC = `RSS_T_RST_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  rss_tmr_if.timer tif
);
  rss_pkg::rss_tcnt_t cnt_r;
  rss_pkg::rss_tcnt_t cnt_nxt;
  logic busy_r;
  wire logic cnt_zero = (cnt_r == '0);

  // Reload while the cause lasts, run out after it has gone
  assign cnt_nxt = tif.trig ? rss_pkg::rss_tcnt_t'(T_RST_CYC) :
                   cnt_zero ? cnt_r : cnt_r - 18'h00001;
  assign tif.busy = busy_r;

  // Power-up starts with a full pulse pending
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= rss_pkg::rss_tcnt_t'(T_RST_CYC);
      busy_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      busy_r <= tif.trig | (cnt_nxt != '0);
    end
  end
endmodule // rss_pulse_timer

// ==== hdl/rss_regs.svh ====
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

// Register offsets on the serial link
`define RSS_ADDR_IMR 7'h09
`define RSS_ADDR_IFR 7'h0A
`define RSS_ADDR_CAUSE 7'h0D
`define RSS_ADDR_CTL 7'h10
`define RSS_ADDR_STAT 7'h11

// Reset values
`define RSS_CAUSE_POR_VAL 8'h80
`define RSS_IMR_RST 8'h00
`define RSS_SLEW_20K 2'h0
`define RSS_BYTE_ZERO 8'h00

// Reset cause status bits
`define RSS_CAUSE_POR 7
`define RSS_CAUSE_PIN 6
`define RSS_CAUSE_WDOG 5
`define RSS_CAUSE_HTEMP 4
`define RSS_CAUSE_LVOLT 3
`define RSS_CAUSE_BUSWF 1
`define RSS_CAUSE_WIWF 0

// Mask, flag, control and status bits
`define RSS_IMR_BUSIE 5
`define RSS_IMR_HTDIS 4
`define RSS_IFR_BUSIF 5
`define RSS_CTL_PSTAGE 7
`define RSS_CTL_SLEW_HI 1
`define RSS_CTL_SLEW_LO 0
`define RSS_STAT_BUSCL 0

// Serial frame: write flag, 7-bit address, 8-bit data
`define RSS_FRAME_BITS 5'h10
`define RSS_HDR_LAST 5'h07
`define RSS_DATA_LAST 5'h0F

// Timing
`define RSS_CLK_NS 10
`define RSS_T_RST_NS 1250000
`define RSS_WAKE_FILT_NS 30000
`define RSS_CL_DELAY_NS 10000
`define RSS_T_RST_CYC ((`RSS_T_RST_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_WAKE_FILT_CYC ((`RSS_WAKE_FILT_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_CL_DELAY_CYC ((`RSS_CL_DELAY_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)

`endif

// ==== hdl/rss_tmr_if.sv ====
`timescale 1ns/1ps
interface rss_tmr_if;
  logic trig;
  logic busy;
  modport owner (output trig, input busy);
  modport timer (input trig, output busy);
endinterface

// ==== hdl/rss_top.sv ====
`timescale 1ns/1ps
`include "rss_regs.svh"
module rss_top #(
  parameter int T_RST_CYC = `RSS_T_RST_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_ss_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe_o,
  input wire logic over_temp_i,
  input wire logic wdog_reset_i,
  input wire logic vdd_low_i,
  input wire logic mode_stop_i,
  input wire logic mode_sleep_i,
  input wire logic wake_input_i,
  input wire logic txd_i,
  input wire logic bus_rx_i,
  input wire logic bus_cur_lim_i,
  output logic bus_drive_o,
  output logic rxd_o,
  output logic [1:0] slew_select_o,
  output logic bus_irq_o,
  output logic wake_o
);

  // Serial slave state
  logic sclk_d_r;
  logic [4:0] bit_cnt_r;
  logic [15:0] shift_in_r;
  logic [7:0] shift_out_r;
  logic [6:0] addr_r;
  logic wr_flag_r;
  logic wr_stb_r;
  logic [7:0] wr_data_r;
  logic miso_r;

  // Registers
  logic [7:0] reset_cause_status_r;
  logic [7:0] reset_cause_status_nxt;
  logic [7:0] int_mask_r;
  logic bus_interrupt_flag_r;
  logic bus_interrupt_flag_nxt;
  logic power_stage_on_r;
  logic [1:0] slew_select_r;
  logic bus_current_limit_status_r;
  logic bus_current_limit_status_nxt;

  // Transceiver and wake state
  logic cl_off_r;
  rss_pkg::rss_fcnt_t cl_cnt_r;
  rss_pkg::rss_wake_e wk_st_r;
  rss_pkg::rss_wake_e wk_st_nxt;
  rss_pkg::rss_fcnt_t wk_cnt_r;
  logic lp_d_r;
  logic wi_store_r;
  logic bus_drive_r;
  logic rxd_r;
  logic irq_r;
  logic wake_r;

  // Reset pin
  logic rst_oe_r;
  logic rst_oe_d_r;
  logic rst_out_r;

  rss_tmr_if tmr_if ();

  // Serial edges and frame positions
  wire logic sclk_rise = spi_sclk_i & ~sclk_d_r & ~spi_ss_n_i;
  wire logic sclk_fall = ~spi_sclk_i & sclk_d_r & ~spi_ss_n_i;
  wire logic [7:0] byte_now = {shift_in_r[6:0], spi_mosi_i};
  wire logic hdr_done = sclk_rise & (bit_cnt_r == `RSS_HDR_LAST);
  wire logic data_done = sclk_rise & (bit_cnt_r == `RSS_DATA_LAST);

  // Write decode
  wire logic wr_cause = wr_stb_r & (addr_r == `RSS_ADDR_CAUSE);
  wire logic wr_imr = wr_stb_r & (addr_r == `RSS_ADDR_IMR);
  wire logic wr_ifr = wr_stb_r & (addr_r == `RSS_ADDR_IFR);
  wire logic wr_ctl = wr_stb_r & (addr_r == `RSS_ADDR_CTL);
  wire logic wr_stat = wr_stb_r & (addr_r == `RSS_ADDR_STAT);

  // Mode and control fields
  wire logic low_power = mode_stop_i | mode_sleep_i;
  wire logic high_temp_reset_disable = int_mask_r[`RSS_IMR_HTDIS];
  wire logic bus_interrupt_enable = int_mask_r[`RSS_IMR_BUSIE];

  // Wake events
  wire logic bus_wake_evt = (wk_st_r == rss_pkg::WK_ARMED) & bus_rx_i & low_power;
  wire logic wi_evt = low_power & lp_d_r & (wake_input_i != wi_store_r);
  wire logic sleep_bus_wake = bus_wake_evt & mode_sleep_i;
  wire logic sleep_wi_wake = wi_evt & mode_sleep_i;
  wire logic sleep_wake = sleep_bus_wake | sleep_wi_wake;
  wire logic stop_bus_int = bus_wake_evt & mode_stop_i & bus_interrupt_enable;
  wire logic any_wake = sleep_wake | stop_bus_int | (wi_evt & mode_stop_i);

  // Internal reset sources
  wire logic ht_evt = over_temp_i & ~high_temp_reset_disable;
  wire logic int_rst = ht_evt | wdog_reset_i | vdd_low_i | sleep_wake;
  // Link registers fall back to reset values; cause register is kept
  wire logic soft_rst = int_rst;

  // Pin pulled low by someone else while we do not drive it
  wire logic ext_pin_evt = ~rst_pin_i & ~rst_oe_r & ~rst_oe_d_r;

  wire logic [7:0] cause_set = ({7'h00, sleep_wi_wake} << `RSS_CAUSE_WIWF)
                             | ({7'h00, sleep_bus_wake} << `RSS_CAUSE_BUSWF)
                             | ({7'h00, vdd_low_i} << `RSS_CAUSE_LVOLT)
                             | ({7'h00, ht_evt} << `RSS_CAUSE_HTEMP)
                             | ({7'h00, wdog_reset_i} << `RSS_CAUSE_WDOG)
                             | ({7'h00, ext_pin_evt} << `RSS_CAUSE_PIN);

  // Current limit and transmitter enable
  wire logic cl_expired = (cl_cnt_r == rss_pkg::rss_fcnt_t'(`RSS_CL_DELAY_CYC));
  wire logic tx_en = power_stage_on_r & ~low_power & ~cl_off_r;

  // Sticky flag with set winning over a write-one clear
  function automatic logic [7:0] w1c_upd(input logic [7:0] cur,
                                         input logic wr,
                                         input logic [7:0] data,
                                         input logic [7:0] set);
    w1c_upd = (cur & ~(wr ? data : 8'h00)) | set;
  endfunction

  assign reset_cause_status_nxt = w1c_upd(reset_cause_status_r, wr_cause, wr_data_r, cause_set);
  wire logic [7:0] busif_upd = w1c_upd({7'h00, bus_interrupt_flag_r}, wr_ifr,
                                       {7'h00, wr_data_r[`RSS_IFR_BUSIF]},
                                       {7'h00, stop_bus_int});
  wire logic [7:0] buscl_upd = w1c_upd({7'h00, bus_current_limit_status_r}, wr_stat,
                                       {7'h00, wr_data_r[`RSS_STAT_BUSCL]},
                                       {7'h00, bus_cur_lim_i & tx_en});
  assign bus_interrupt_flag_nxt = busif_upd[0];
  assign bus_current_limit_status_nxt = buscl_upd[0];

  // Read data for the addressed register
  wire logic [6:0] rd_addr = byte_now[6:0];
  wire logic [7:0] ifr_rd = {2'h0, bus_interrupt_flag_r, 5'h00};
  wire logic [7:0] ctl_rd = {power_stage_on_r, 5'h00, slew_select_r};
  wire logic [7:0] stat_rd = {7'h00, bus_current_limit_status_r};
  wire logic [7:0] rd_data = (rd_addr == `RSS_ADDR_CAUSE) ? reset_cause_status_r :
                             (rd_addr == `RSS_ADDR_IMR) ? int_mask_r :
                             (rd_addr == `RSS_ADDR_IFR) ? ifr_rd :
                             (rd_addr == `RSS_ADDR_CTL) ? ctl_rd :
                             (rd_addr == `RSS_ADDR_STAT) ? stat_rd :
                             `RSS_BYTE_ZERO;

  // Bus wake qualifier: dominant longer than the filter, then a rising edge
  wire logic wk_long = (wk_cnt_r >= rss_pkg::rss_fcnt_t'(`RSS_WAKE_FILT_CYC));
  always_comb begin
    wk_st_nxt = wk_st_r;
    unique case (wk_st_r)
      rss_pkg::WK_IDLE: begin
        if (low_power && !bus_rx_i) begin
          wk_st_nxt = rss_pkg::WK_LOW;
        end
      end
      rss_pkg::WK_LOW: begin
        if (!low_power || bus_rx_i) begin
          wk_st_nxt = rss_pkg::WK_IDLE;
        end else if (wk_long) begin
          wk_st_nxt = rss_pkg::WK_ARMED;
        end
      end
      rss_pkg::WK_ARMED: begin
        if (!low_power || bus_rx_i) begin
          wk_st_nxt = rss_pkg::WK_IDLE;
        end
      end
      default: begin
        wk_st_nxt = rss_pkg::WK_IDLE;
      end
    endcase
  end

  // Serial slave: sample on rising clock, shift out on falling
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_d_r <= 1'b0;
      bit_cnt_r <= 5'h00;
      shift_in_r <= 16'h0000;
    end else begin
      sclk_d_r <= spi_sclk_i;
      if (spi_ss_n_i) begin
        bit_cnt_r <= 5'h00;
      end else if (sclk_rise) begin
        bit_cnt_r <= (bit_cnt_r == `RSS_DATA_LAST) ? 5'h00 : bit_cnt_r + 5'h01;
        shift_in_r <= {shift_in_r[14:0], spi_mosi_i};
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_r <= 7'h00;
      wr_flag_r <= 1'b0;
      shift_out_r <= 8'h00;
      miso_r <= 1'b0;
    end else begin
      if (hdr_done) begin
        addr_r <= byte_now[6:0];
        wr_flag_r <= byte_now[7];
        shift_out_r <= rd_data;
      end else if (sclk_fall) begin
        miso_r <= shift_out_r[7];
        shift_out_r <= {shift_out_r[6:0], 1'b0};
      end
    end
  end

  // Aborted frames never write: the strobe needs all sixteen bits
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_stb_r <= 1'b0;
      wr_data_r <= 8'h00;
    end else begin
      wr_stb_r <= data_done & wr_flag_r;
      if (data_done) begin
        wr_data_r <= byte_now;
      end
    end
  end

  // Cause register survives every reset except power-on
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_cause_status_r <= `RSS_CAUSE_POR_VAL;
    end else begin
      reset_cause_status_r <= reset_cause_status_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_mask_r <= `RSS_IMR_RST;
      bus_interrupt_flag_r <= 1'b0;
    end else if (soft_rst) begin
      int_mask_r <= `RSS_IMR_RST;
      bus_interrupt_flag_r <= 1'b0;
    end else begin
      if (wr_imr) begin
        int_mask_r <= wr_data_r;
      end
      bus_interrupt_flag_r <= bus_interrupt_flag_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_stage_on_r <= 1'b0;
      slew_select_r <= `RSS_SLEW_20K;
      bus_current_limit_status_r <= 1'b0;
    end else if (soft_rst) begin
      power_stage_on_r <= 1'b0;
      slew_select_r <= `RSS_SLEW_20K;
      bus_current_limit_status_r <= 1'b0;
    end else begin
      if (wr_ctl) begin
        power_stage_on_r <= wr_data_r[`RSS_CTL_PSTAGE];
        slew_select_r <= wr_data_r[`RSS_CTL_SLEW_HI:`RSS_CTL_SLEW_LO];
      end
      bus_current_limit_status_r <= bus_current_limit_status_nxt;
    end
  end

  // Driver shuts off once limiting lasts the delay; clearing the status re-arms it
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cl_cnt_r <= '0;
      cl_off_r <= 1'b0;
    end else if (soft_rst) begin
      cl_cnt_r <= '0;
      cl_off_r <= 1'b0;
    end else begin
      if (!(bus_cur_lim_i && tx_en)) begin
        cl_cnt_r <= '0;
      end else if (!cl_expired) begin
        cl_cnt_r <= cl_cnt_r + 12'h001;
      end
      if (cl_expired) begin
        cl_off_r <= 1'b1;
      end else if (!bus_current_limit_status_r) begin
        cl_off_r <= 1'b0;
      end
    end
  end

  // Receiver keeps running in stop and sleep for wake detection
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wk_st_r <= rss_pkg::WK_IDLE;
      wk_cnt_r <= '0;
    end else begin
      wk_st_r <= wk_st_nxt;
      if (wk_st_r == rss_pkg::WK_LOW && !wk_long) begin
        wk_cnt_r <= wk_cnt_r + 12'h001;
      end else if (wk_st_r == rss_pkg::WK_IDLE) begin
        wk_cnt_r <= '0;
      end
    end
  end

  // Level taken on mode entry and again after each event, so a wake is one pulse
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lp_d_r <= 1'b0;
      wi_store_r <= 1'b0;
    end else begin
      lp_d_r <= low_power;
      if ((low_power && !lp_d_r) || wi_evt) begin
        wi_store_r <= wake_input_i;
      end
    end
  end

  // Bus pins: an undriven transmit input is pulled high outside the die
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_drive_r <= 1'b0;
      rxd_r <= 1'b1;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      bus_drive_r <= tx_en & ~txd_i;
      rxd_r <= bus_rx_i;
      irq_r <= bus_interrupt_flag_nxt & bus_interrupt_enable & ~soft_rst;
      wake_r <= any_wake;
    end
  end

  // Reset pin held low through power-up and every internal reset
  assign tmr_if.trig = int_rst;

  rss_pulse_timer #(
    .T_RST_CYC(T_RST_CYC)
  ) u_pulse (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .tif(tmr_if)
  );

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_oe_r <= 1'b1;
      rst_oe_d_r <= 1'b1;
      rst_out_r <= 1'b0;
    end else begin
      rst_oe_r <= tmr_if.busy;
      rst_oe_d_r <= rst_oe_r;
      rst_out_r <= 1'b0;
    end
  end

  assign spi_miso_o = miso_r;
  assign rst_pin_o = rst_out_r;
  assign rst_pin_oe_o = rst_oe_r;
  assign bus_drive_o = bus_drive_r;
  assign rxd_o = rxd_r;
  assign slew_select_o = slew_select_r;
  assign bus_irq_o = irq_r;
  assign wake_o = wake_r;

endmodule // rss_top

// ==== tb/reset_source_status_tb.sv ====
`timescale 1ns/1ps
module reset_source_status_tb;
  localparam int TR = 50;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic spi_sclk_i, spi_ss_n_i, spi_mosi_i, rst_pin_i;
  logic over_temp_i = 1'b0, wdog_reset_i = 1'b0, vdd_low_i = 1'b0;
  logic mode_stop_i = 1'b0, mode_sleep_i = 1'b0, wake_input_i = 1'b0;
  logic txd_i = 1'b1, bus_rx_i = 1'b1, bus_cur_lim_i = 1'b0;
  logic spi_miso_o, rst_pin_o, rst_pin_oe_o, bus_drive_o, rxd_o, bus_irq_o, wake_o;
  logic [1:0] slew_select_o;
  logic wake_seen = 1'b0;
  int n_mismatch = 0, compares = 0, cyc = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  rss_top #(.T_RST_CYC(TR)) i_dut (.*);
  rss_mcu_model i_mcu (.clk_sys_i(clk_sys_i), .spi_miso_i(spi_miso_o),
    .rst_pin_oe_i(rst_pin_oe_o), .spi_sclk_o(spi_sclk_i), .spi_ss_n_o(spi_ss_n_i),
    .spi_mosi_o(spi_mosi_i), .rst_pin_o(rst_pin_i));
  always @(posedge clk_sys_i) begin
    if (wake_o === 1'b1) wake_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic summarize;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic clk_n(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    i_mcu.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    i_mcu.xfer(1'b1, a, d, x);
  endtask
  task automatic t_por;
    clk_n(TR - 2);
    chk(8'(rst_pin_oe_o), 8'h01);
    clk_n(10);
    chk(8'(rst_pin_oe_o), 8'h00);
    chk(8'(slew_select_o), 8'h00);
    rd(7'h0D, 8'h80);
    wr(7'h0D, 8'h00);
    rd(7'h0D, 8'h80);
    wr(7'h0D, 8'h80);
    rd(7'h0D, 8'h00);
    rd(7'h3F, 8'h00);
  endtask
  // Flags are not cleared between causes, so they must pile up
  task automatic t_causes;
    logic [7:0] bits [3];
    logic [7:0] acc;
    bits = '{8'h20, 8'h08, 8'h10};
    acc = 8'h00;
    for (int k = 0; k < 3; k++) begin
      wr(7'h09, 8'h20);
      wr(7'h10, 8'h83);
      @(posedge clk_sys_i);
      wdog_reset_i <= (k == 0);
      vdd_low_i <= (k == 1);
      over_temp_i <= (k == 2);
      clk_n(4);
      chk(8'(rst_pin_oe_o), 8'h01);
      @(posedge clk_sys_i);
      {wdog_reset_i, vdd_low_i, over_temp_i} <= 3'h0;
      clk_n(TR - 4);
      chk(8'(rst_pin_oe_o), 8'h01);
      clk_n(14);
      chk(8'(rst_pin_oe_o), 8'h00);
      acc = acc | bits[k];
      rd(7'h0D, acc);
      rd(7'h09, 8'h00);
      rd(7'h10, 8'h00);
    end
    wr(7'h0D, 8'hFF);
    rd(7'h0D, 8'h00);
  endtask
  task automatic t_high_temp_reset_disable;
    wr(7'h09, 8'h10);
    @(posedge clk_sys_i);
    over_temp_i <= 1'b1;
    clk_n(6);
    chk(8'(rst_pin_oe_o), 8'h00);
    @(posedge clk_sys_i);
    over_temp_i <= 1'b0;
    rd(7'h09, 8'h10);
    wr(7'h09, 8'h00);
    i_mcu.pull_rst(4);
    clk_n(3);
    rd(7'h0D, 8'h40);
    clk_n(TR + 12);
    @(posedge clk_sys_i);
    vdd_low_i <= 1'b1;
    wr(7'h0D, 8'hFF);
    @(posedge clk_sys_i);
    vdd_low_i <= 1'b0;
    rd(7'h0D, 8'h08);
    wr(7'h0D, 8'hFF);
  endtask
  task automatic drv(input logic t, input logic s, input logic [7:0] e);
    @(posedge clk_sys_i);
    txd_i <= t;
    mode_stop_i <= s;
    bus_rx_i <= t | s;
    clk_n(3);
    chk(8'(bus_drive_o), e);
    chk(8'(rxd_o), 8'(t | s));
  endtask
  task automatic t_tx;
    wr(7'h10, 8'h82);
    clk_n(2);
    chk(8'(slew_select_o), 8'h02);
    drv(1'b0, 1'b0, 8'h01);
    drv(1'b0, 1'b1, 8'h00);
    drv(1'b1, 1'b0, 8'h00);
    wr(7'h10, 8'h02);
    drv(1'b0, 1'b0, 8'h00);
    wr(7'h10, 8'h80);
    @(posedge clk_sys_i);
    bus_cur_lim_i <= 1'b1;
    clk_n(1010);
    chk(8'(bus_drive_o), 8'h00);
    @(posedge clk_sys_i);
    bus_cur_lim_i <= 1'b0;
    rd(7'h11, 8'h01);
    wr(7'h11, 8'h01);
    clk_n(3);
    chk(8'(bus_drive_o), 8'h01);
    drv(1'b1, 1'b0, 8'h00);
  endtask
  // n == 0 wakes by the wake input, otherwise by n cycles of dominant bus
  task automatic lowpwr(input logic slp, input int n);
    @(posedge clk_sys_i);
    mode_sleep_i <= slp;
    mode_stop_i <= !slp;
    wake_seen <= 1'b0;
    clk_n(3);
    @(posedge clk_sys_i);
    if (n == 0) wake_input_i <= !wake_input_i;
    else bus_rx_i <= 1'b0;
    repeat (n) @(posedge clk_sys_i);
    bus_rx_i <= 1'b1;
    clk_n(12);
  endtask
  task automatic idle;
    @(posedge clk_sys_i);
    {mode_sleep_i, mode_stop_i} <= 2'h0;
    clk_n(TR + 12);
  endtask
  task automatic t_wake;
    lowpwr(1'b1, 3010);
    chk(8'(wake_seen), 8'h01);
    idle();
    rd(7'h0D, 8'h02);
    wr(7'h0D, 8'h02);
    lowpwr(1'b1, 0);
    chk(8'(wake_seen), 8'h01);
    idle();
    rd(7'h0D, 8'h01);
    wr(7'h0D, 8'h01);
    wr(7'h09, 8'h20);
    lowpwr(1'b0, 2900);
    chk(8'(wake_seen), 8'h00);
    lowpwr(1'b0, 3010);
    chk(8'(bus_irq_o), 8'h01);
    idle();
    rd(7'h0A, 8'h20);
    wr(7'h0A, 8'h20);
    clk_n(3);
    chk(8'(bus_irq_o), 8'h00);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_por();
    t_causes();
    t_high_temp_reset_disable();
    t_tx();
    t_wake();
    summarize();
  end
endmodule // reset_source_status_tb

// ==== tb/rss_mcu_model.sv ====
`timescale 1ns/1ps
module rss_mcu_model (
  input wire logic clk_sys_i,
  input wire logic spi_miso_i,
  input wire logic rst_pin_oe_i,
  output logic spi_sclk_o,
  output logic spi_ss_n_o,
  output logic spi_mosi_o,
  output logic rst_pin_o
);
  logic pull_low = 1'b0;
  // Pulled-up open-drain pin: low while either side drives it
  assign rst_pin_o = !(rst_pin_oe_i || pull_low);
  initial begin
    spi_sclk_o = 1'b0;
    spi_ss_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // Four clocks high and five low per bit, at least twice what the sampler needs
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [15:0] f;
    f = {wr, a, d};
    q = 8'h00;
    @(posedge clk_sys_i);
    spi_ss_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_sys_i);
      spi_mosi_o <= f[i];
      tick(4);
      spi_sclk_o <= 1'b1;
      if (i < 8) q[i] = spi_miso_i;
      tick(4);
      spi_sclk_o <= 1'b0;
    end
    tick(2);
    spi_ss_n_o <= 1'b1;
    // Released line must not keep showing the last bit
    spi_mosi_o <= !spi_mosi_o;
    tick(4);
  endtask
  task automatic pull_rst(input int n);
    @(posedge clk_sys_i);
    pull_low <= 1'b1;
    tick(n);
    pull_low <= 1'b0;
  endtask
endmodule // rss_mcu_model

// ==== tb/rss_props.sv ====
`timescale 1ns/1ps
module rss_props #(
  parameter int T_RST_CYC = 50
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_ss_n_i,
  input wire logic spi_mosi_i,
  input wire logic spi_miso_o,
  input wire logic rst_pin_i,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_o,
  input wire logic over_temp_i,
  input wire logic wdog_reset_i,
  input wire logic vdd_low_i,
  input wire logic mode_stop_i,
  input wire logic mode_sleep_i,
  input wire logic wake_input_i,
  input wire logic txd_i,
  input wire logic bus_rx_i,
  input wire logic bus_cur_lim_i,
  input wire logic bus_drive_o,
  input wire logic rxd_o,
  input wire logic [1:0] slew_select_o,
  input wire logic bus_irq_o,
  input wire logic wake_o
);
  // Run length of current limit, saturating so it never wraps back to zero
  logic [10:0] cl_cnt;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) cl_cnt <= 11'h000;
    else if (!bus_cur_lim_i) cl_cnt <= 11'h000;
    else if (cl_cnt != 11'h7FF) cl_cnt <= cl_cnt + 11'h001;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_wdog_gone;
    $fell(wdog_reset_i);
  endsequence
  sequence s_pin_held;
    rst_pin_oe_o [*8];
  endsequence
  a_pin_value: assert property (rst_pin_o == 1'b0)
    else $error("reset pin value not low");
  a_wdog_pin: assert property (wdog_reset_i |-> ##[1:3] rst_pin_oe_o)
    else $error("watchdog did not drive reset pin");
  a_vdd_pin: assert property (vdd_low_i |-> ##[1:3] rst_pin_oe_o)
    else $error("low supply did not drive reset pin");
  a_pin_hold: assert property (s_wdog_gone |-> ##1 s_pin_held)
    else $error("reset pin released too early");
  a_lowpwr_tx: assert property ((mode_stop_i || mode_sleep_i) |=> !bus_drive_o)
    else $error("transmitter on in low power");
  a_tx_level: assert property (bus_drive_o |-> $past(txd_i) == 1'b0)
    else $error("bus driven without low transmit input");
  a_rx_follow: assert property (rxd_o == $past(bus_rx_i))
    else $error("receive output not following bus");
  a_wake_pulse: assert property (wake_o |=> !wake_o)
    else $error("wake pulse longer than one cycle");
  a_cl_cut: assert property ((cl_cnt > 11'h3EB) |-> !bus_drive_o)
    else $error("driver still on after current limit");
endmodule // rss_props
bind rss_top rss_props #(.T_RST_CYC(T_RST_CYC)) i_props (.*);
